//--- shared/motor_regs_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * of the motor drive control and diagnostic register bank.
 * Assumes inclusion by bare name from a file that uses the macros.
 */
`ifndef MOTOR_REGS_DEFS_SVH
`define MOTOR_REGS_DEFS_SVH

// Register indices on the serial link (word addresses)
`define OFS_CFG18        8'h12
`define OFS_CFG19        8'h13
`define OFS_CFG20        8'h14
`define OFS_CFG21        8'h15
`define OFS_NV_SAVE      8'h1c
`define OFS_FAULT_MASK   8'h1d
`define OFS_FAULT_OUTPUT_PIN         8'h1e
`define OFS_RUN_CTRL     8'h1f

// Reset values
`define RST_CFG18        16'h0366
`define RST_CFG19        16'h01b3
`define RST_CFG20        16'h015c
`define RST_CFG21        16'h00ae
`define RST_MASK         16'h0000
`define RST_RUN_CTRL     16'h0092

// Field positions
`define BIT_SAVE         9
`define BIT_RUN          0
`define BIT_DIR          1
`define BIT_BRAKE        2
`define BIT_PULSE_SEL    4
`define FAULT_OUTPUT_PIN_SEL_LSB     2
`define FAULT_LSB        3

// Timing: a save occupies the memory for this time
`define NV_WRITE_US      10
`define CLK_MHZ          40
`define NV_WRITE_CYC     (`NV_WRITE_US * `CLK_MHZ)
// Watchdog: control must service within this time
`define WDOG_US          1000
`define WDOG_CYC         (`WDOG_US * `CLK_MHZ)
// Analog speed input low this long enters low power
`define LOWPWR_US        500
`define LOWPWR_CYC       (`LOWPWR_US * `CLK_MHZ)

`endif

//--- shared/motor_regs_pkg.sv
/*
 * Types shared by the motor drive register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package motor_regs_pkg;
   // Seven individual fault events, bit 6 thermal warning .. bit 0 undervoltage
   typedef struct packed {
      logic thermal_warning_flag;
      logic overtemperature_flag;
      logic sync_loss_flag;
      logic phase_fault_flag;
      logic hard_overcurrent_flag;
      logic supply_overvoltage_flag;
      logic supply_undervoltage_flag;
   } fault_vec_t;

   // Register access request from the serial slave
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {NV_IDLE, NV_WRITE} nv_state_t;
endpackage

//--- hw/motor_drive_control_fault_output_pin_regs.sv
/*
 * Control, fault-mask, diagnostic and non-volatile save registers of a
 * sensorless three-phase motor driver.
 * Assumes: register requests arrive decoded from the serial slave on ref_clk;
 * pins (clear, direction, analog-low, fault events) are asynchronous.
 */
// Summary of operation
// - Clear low stops drive, clears diagnostics
// - After clear, fault pin returns high
// - Direction is register bit XOR pin
// - Speed from serial value or analog input
// - Settings kept in non-volatile memory
// - Watchdog halts run when not serviced
// - Fault pin behaviour selected by diagnostic fields
// - Overcurrent limits motor current
// - Register 28 bit 9 starts save
// - Register 28 reads ten-bit write count
// - Register 29 masks seven faults
// - Register 30 reads summary and fault flags
// - Pulse rate one or three times
// - Analog input held low enters low power
`include "motor_regs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module motor_drive_control_fault_output_pin_regs #(
   parameter int WDOG_CYCLES   = `WDOG_CYC,
   parameter int LOWPWR_CYCLES = `LOWPWR_CYC
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   input  wire motor_regs_pkg::reg_req_t req,
   output logic [15:0]                   rdata,
   input  wire logic                     clear_input_low,
   input  wire logic                     direction_pin,
   input  wire logic                     analog_speed_low,
   input  wire motor_regs_pkg::fault_vec_t fault_events,
   input  wire logic                     overcurrent_event,
   input  wire logic                     memory_error_event,
   input  wire logic                     wdog_service,
   input  wire logic                     nv_done,
   output logic                          fault_output_pin,
   output logic                          drive_enable,
   output logic                          reverse_dir,
   output logic                          brake_out,
   output logic                          current_limit,
   output logic                          speed_from_serial,
   output logic                          pulse_rate_select,
   output logic                          low_power,
   output logic                          nv_save_trigger
);
   // Two-stage synchronisers for asynchronous pins
   logic [11:0] sync1_r;
   logic [11:0] sync2_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_r <= 12'h001;
         sync2_r <= 12'h001;
      end else begin
         sync1_r <= {fault_events, overcurrent_event, memory_error_event,
                     analog_speed_low, direction_pin, clear_input_low};
         sync2_r <= sync1_r;
      end
   end

   wire                         clr_n_s   = sync2_r[0];
   wire                         dir_s     = sync2_r[1];
   wire                         alow_s    = sync2_r[2];
   wire                         mem_err_s = sync2_r[3];
   wire                         oc_s      = sync2_r[4];
   wire motor_regs_pkg::fault_vec_t flt_s = sync2_r[11:5];

   // Registers
   logic [15:0] cfg18_r, cfg19_r, cfg20_r, cfg21_r;
   logic [6:0]  mask_r;
   logic [2:0]  fault_output_pin_sel_r;
   logic [9:0]  run_r;
   logic [6:0]  fault_r;
   logic        por_r, me_r, wd_r, oc_r, ee_r;
   logic [9:0]  nvc_r;
   motor_regs_pkg::nv_state_t nv_state_r;
   logic [15:0] nv_cnt_r;
   logic [31:0] wd_cnt_r;
   logic [31:0] lp_cnt_r;

   // Address decode
   wire wr_cfg18 = req.wr && req.addr == `OFS_CFG18;
   wire wr_cfg19 = req.wr && req.addr == `OFS_CFG19;
   wire wr_cfg20 = req.wr && req.addr == `OFS_CFG20;
   wire wr_cfg21 = req.wr && req.addr == `OFS_CFG21;
   wire wr_save  = req.wr && req.addr == `OFS_NV_SAVE && req.wdata[`BIT_SAVE];
   wire wr_mask  = req.wr && req.addr == `OFS_FAULT_MASK;
   wire wr_fault_output_pin  = req.wr && req.addr == `OFS_FAULT_OUTPUT_PIN;
   wire wr_run   = req.wr && req.addr == `OFS_RUN_CTRL;

   // Flag sources: unmasked faults and summary
   wire [6:0] fault_in   = flt_s & ~mask_r;
   wire       wd_expire  = run_r[`BIT_RUN] && wd_cnt_r >= WDOG_CYCLES - 1;
   wire       any_fault  = (|fault_r) | me_r | wd_r | oc_r | ee_r;
   wire [5:0] summary    = {any_fault, por_r, me_r, wd_r, oc_r, ee_r};
   wire       nv_start   = wr_save && nv_state_r == motor_regs_pkg::NV_IDLE;

   // Configuration, mask and control registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg18_r    <= `RST_CFG18;
         cfg19_r    <= `RST_CFG19;
         cfg20_r    <= `RST_CFG20;
         cfg21_r    <= `RST_CFG21;
         mask_r     <= 7'h00;
         fault_output_pin_sel_r <= 3'h0;
         run_r      <= 10'(`RST_RUN_CTRL);
      end else begin
         if (wr_cfg18) cfg18_r <= req.wdata;
         if (wr_cfg19) cfg19_r <= req.wdata;
         if (wr_cfg20) cfg20_r <= req.wdata;
         if (wr_cfg21) cfg21_r <= req.wdata;
         if (wr_mask) mask_r <= req.wdata[9:3];
         if (wr_fault_output_pin) fault_output_pin_sel_r <= req.wdata[4:2];
         if (!clr_n_s || wd_expire) begin
            run_r[`BIT_RUN] <= 1'b0;
         end else if (wr_run) begin
            run_r <= req.wdata[9:0];
         end
      end
   end

   // Diagnostic flags: set wins over clear except the clear pin
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fault_r <= 7'h00;
         por_r   <= 1'b1;
         me_r    <= 1'b0;
         wd_r    <= 1'b0;
         oc_r    <= 1'b0;
         ee_r    <= 1'b0;
      end else if (!clr_n_s) begin
         fault_r <= 7'h00;
         por_r   <= 1'b0;
         me_r    <= 1'b0;
         wd_r    <= 1'b0;
         oc_r    <= 1'b0;
         ee_r    <= 1'b0;
      end else begin
         fault_r <= fault_r | fault_in;
         me_r    <= me_r | mem_err_s;
         wd_r    <= wd_r | wd_expire;
         oc_r    <= oc_r | oc_s;
         ee_r    <= ee_r | (wr_save && nv_state_r != motor_regs_pkg::NV_IDLE);
      end
   end

   // Non-volatile save sequencer and write counter
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         nv_state_r <= motor_regs_pkg::NV_IDLE;
         nv_cnt_r   <= 16'h0000;
         nvc_r      <= 10'h000;
      end else begin
         unique case (nv_state_r)
            motor_regs_pkg::NV_IDLE: begin
               if (nv_start) begin
                  nv_state_r <= motor_regs_pkg::NV_WRITE;
                  nv_cnt_r   <= 16'h0000;
               end
            end
            motor_regs_pkg::NV_WRITE: begin
               nv_cnt_r <= nv_cnt_r + 16'h0001;
               if (nv_done || nv_cnt_r == 16'(`NV_WRITE_CYC - 1)) begin
                  nv_state_r <= motor_regs_pkg::NV_IDLE;
                  nvc_r      <= nvc_r + 10'h001;
               end
            end
            default: nv_state_r <= motor_regs_pkg::NV_IDLE;
         endcase
      end
   end

   // Watchdog and low-power timers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wd_cnt_r <= 32'h0;
         lp_cnt_r <= 32'h0;
      end else begin
         wd_cnt_r <= (wdog_service || !run_r[`BIT_RUN]) ? 32'h0 : wd_cnt_r + 32'h1;
         if (!alow_s) lp_cnt_r <= 32'h0;
         else if (lp_cnt_r < LOWPWR_CYCLES) lp_cnt_r <= lp_cnt_r + 32'h1;
      end
   end

   // Read mux
   logic [15:0] rd_nxt;
   always_comb begin
      unique case (req.addr)
         `OFS_CFG18:      rd_nxt = cfg18_r;
         `OFS_CFG19:      rd_nxt = cfg19_r;
         `OFS_CFG20:      rd_nxt = cfg20_r;
         `OFS_CFG21:      rd_nxt = cfg21_r;
         `OFS_NV_SAVE:    rd_nxt = {6'h00, nvc_r};
         `OFS_FAULT_MASK: rd_nxt = {6'h00, mask_r, 3'h0};
         `OFS_FAULT_OUTPUT_PIN:       rd_nxt = {summary, fault_r, 3'h0};
         `OFS_RUN_CTRL:   rd_nxt = {summary, run_r};
         default:         rd_nxt = 16'h0000;
      endcase
   end

   // Fault pin: selected sources; low = fault, high when all flags clear
   wire fault_sel = (fault_output_pin_sel_r[0] & (|fault_r)) | (fault_output_pin_sel_r[1] & (oc_r | wd_r))
                  | (fault_output_pin_sel_r[2] & (me_r | ee_r)) | (fault_output_pin_sel_r == 3'h0 & any_fault);

   // Registered outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata             <= 16'h0000;
         fault_output_pin  <= 1'b1;
         drive_enable      <= 1'b0;
         reverse_dir       <= 1'b0;
         brake_out         <= 1'b0;
         current_limit     <= 1'b0;
         speed_from_serial <= 1'b0;
         pulse_rate_select <= 1'b0;
         low_power         <= 1'b0;
         nv_save_trigger   <= 1'b0;
      end else begin
         rdata             <= req.rd ? rd_nxt : 16'h0000;
         fault_output_pin  <= !clr_n_s ? 1'b1 : !fault_sel;
         drive_enable      <= clr_n_s && run_r[`BIT_RUN] && !wd_expire && !(|fault_r);
         reverse_dir       <= run_r[`BIT_DIR] ^ dir_s;
         brake_out         <= run_r[`BIT_BRAKE];
         current_limit     <= oc_s;
         speed_from_serial <= cfg19_r[0];
         pulse_rate_select <= cfg18_r[`BIT_PULSE_SEL];
         low_power         <= lp_cnt_r >= LOWPWR_CYCLES;
         nv_save_trigger   <= nv_start;
      end
   end

   // Assertions
   a_clear_stops_drive: assert property (@(posedge ref_clk) disable iff (rst)
      !clr_n_s |=> !drive_enable) else $error("drive not stopped by clear");
   a_clear_pin_high: assert property (@(posedge ref_clk) disable iff (rst)
      !clr_n_s |=> fault_output_pin) else $error("fault pin not high after clear");
   a_direction_xor: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1 |=> reverse_dir == ($past(run_r[`BIT_DIR]) ^ $past(dir_s))) else $error("direction wrong");
   a_wdog_halt: assert property (@(posedge ref_clk) disable iff (rst)
      (wd_expire && clr_n_s) |=> !run_r[`BIT_RUN] && wd_r) else $error("watchdog did not halt");
   a_save_starts: assert property (@(posedge ref_clk) disable iff (rst)
      nv_start |=> nv_save_trigger && nv_state_r == motor_regs_pkg::NV_WRITE) else $error("save not started");
   a_count_step: assert property (@(posedge ref_clk) disable iff (rst)
      (nv_state_r == motor_regs_pkg::NV_WRITE && nv_done) |=> nvc_r == $past(nvc_r) + 10'h001)
      else $error("write count not advanced");
   a_mask_blocks: assert property (@(posedge ref_clk) disable iff (rst)
      (clr_n_s && fault_r == 7'h00 && (flt_s & ~mask_r) == 7'h00) |=> fault_r == 7'h00)
      else $error("masked fault latched");
   a_ocl_limit: assert property (@(posedge ref_clk) disable iff (rst)
      oc_s |=> current_limit) else $error("current not limited");
endmodule // motor_drive_control_fault_output_pin_regs

`default_nettype wire

//--- verif/host_ctrl_model.sv
/*
 * Host controller model: issues register requests and drives the clear pin.
 * Assumes one ref_clk domain; requests change 2 ns after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module host_ctrl_model (
   input  wire logic                 ref_clk,
   input  wire logic [15:0]          rdata,
   output motor_regs_pkg::reg_req_t  req,
   output logic                      clear_input_low
);
   // Idle bus, clear held low through power-up
   initial begin
      req = '0;
      clear_input_low = 1'b0;
   end

   // Drive the clear pin level
   task automatic set_clear(input logic lvl);
      @(posedge ref_clk) #2;
      clear_input_low = lvl;
   endtask

   // One-cycle write; released data shows its inverse
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk) #2;
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk) #2;
      req.wr = 1'b0;
      req.wdata = ~d;
   endtask

   // One-cycle read; data taken the cycle after
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk) #2;
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: req.wdata};
      @(posedge ref_clk) #2;
      req.rd = 1'b0;
      d = rdata;
   endtask
endmodule // host_ctrl_model

`default_nettype wire

//--- verif/motor_drive_control_fault_output_pin_regs_test.sv
/*
 * Self-checking bench of the motor drive register bank.
 * Assumes the host model, the package and the defines header.
 */
`include "motor_regs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module motor_drive_control_fault_output_pin_regs_test;
   logic                       ref_clk = 1'b0;
   logic                       rst = 1'b1;
   motor_regs_pkg::reg_req_t   req;
   motor_regs_pkg::fault_vec_t fault_events;
   logic [15:0]                rdata, d;
   logic                       clear_input_low, fault_output_pin, drive_enable, reverse_dir, brake_out;
   logic                       current_limit, speed_from_serial, pulse_rate_select, low_power, nv_save_trigger;
   logic                       direction_pin, analog_speed_low, overcurrent_event;
   logic                       memory_error_event, wdog_service, nv_done;
   int                         fails = 0, num_checks = 0, n;

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
   $display("Error at %0t: got %h expected %h", $time, a, e); end end

   always #12.5 ref_clk = ~ref_clk;

   host_ctrl_model host (.ref_clk(ref_clk), .rdata(rdata), .req(req), .clear_input_low(clear_input_low));

   motor_drive_control_fault_output_pin_regs #(.WDOG_CYCLES(50), .LOWPWR_CYCLES(20)) uut (
      .ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .clear_input_low(clear_input_low),
      .direction_pin(direction_pin), .analog_speed_low(analog_speed_low), .fault_events(fault_events),
      .overcurrent_event(overcurrent_event), .memory_error_event(memory_error_event),
      .wdog_service(wdog_service), .nv_done(nv_done), .fault_output_pin(fault_output_pin),
      .drive_enable(drive_enable), .reverse_dir(reverse_dir), .brake_out(brake_out),
      .current_limit(current_limit), .speed_from_serial(speed_from_serial),
      .pulse_rate_select(pulse_rate_select), .low_power(low_power), .nv_save_trigger(nv_save_trigger));

   // Wait whole cycles, land just after the edge
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #2;
   endtask

   // Pulse the clear pin low
   task automatic clr();
      host.set_clear(1'b0);
      cyc(3);
      host.set_clear(1'b1);
      cyc(4);
   endtask

   // Verdict and end of run
   task automatic end_sim();
      if (fails == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      #2000000;
      fails++;
      end_sim();
   end

   // Main sequence
   initial begin
      fault_events = '0;
      direction_pin = 1'b0;
      analog_speed_low = 1'b0;
      overcurrent_event = 1'b0;
      memory_error_event = 1'b0;
      wdog_service = 1'b0;
      nv_done = 1'b0;
      repeat (6) @(posedge ref_clk);
      #2 rst = 1'b0;
      host.set_clear(1'b1);
      cyc(4);
      // Reset values
      host.rd(`OFS_CFG18, d); `CHK(d, `RST_CFG18)
      host.rd(`OFS_CFG21, d); `CHK(d, `RST_CFG21)
      host.rd(`OFS_FAULT_MASK, d); `CHK(d, `RST_MASK)
      host.rd(`OFS_RUN_CTRL, d); `CHK(d & 16'h03ff, `RST_RUN_CTRL)
      `CHK(speed_from_serial, 1'b1)
      `CHK(pulse_rate_select, 1'b0)
      // Each fault alone sets its own flag and the pin
      for (int i = 0; i < 7; i++) begin
         fault_events = 7'(1 << i);
         clr();
         cyc(5);
         host.rd(`OFS_FAULT_OUTPUT_PIN, d); `CHK(d[9:3], 7'(1 << i))
         `CHK(d[15], 1'b1)
         `CHK(fault_output_pin, 1'b0)
      end
      // Clear empties diagnostics and releases the pin
      fault_events = '0;
      clr();
      host.rd(`OFS_FAULT_OUTPUT_PIN, d); `CHK(d, 16'h0000)
      `CHK(fault_output_pin, 1'b1)
      // Masked faults stay hidden
      host.wr(`OFS_FAULT_MASK, 16'h03f8);
      host.rd(`OFS_FAULT_MASK, d); `CHK(d, 16'h03f8)
      fault_events = '1;
      cyc(5);
      host.rd(`OFS_FAULT_OUTPUT_PIN, d); `CHK(d[9:3], 7'h00)
      // Pin fed by overcurrent and watchdog only
      host.wr(`OFS_FAULT_MASK, 16'h0000);
      host.wr(`OFS_FAULT_OUTPUT_PIN, 16'h0008);
      cyc(5);
      `CHK(fault_output_pin, 1'b1)
      overcurrent_event = 1'b1;
      cyc(5);
      `CHK(fault_output_pin, 1'b0)
      `CHK(current_limit, 1'b1)
      host.rd(`OFS_FAULT_OUTPUT_PIN, d); `CHK(d[11], 1'b1)
      overcurrent_event = 1'b0;
      fault_events = '0;
      host.wr(`OFS_FAULT_OUTPUT_PIN, 16'h0000);
      // Direction from register bit and pin
      for (int i = 0; i < 4; i++) begin
         host.wr(`OFS_RUN_CTRL, {14'h0000, i[1], 1'b0});
         direction_pin = i[0];
         cyc(5);
         `CHK(reverse_dir, i[0] ^ i[1])
      end
      // Run with service, then starve the watchdog
      clr();
      host.wr(`OFS_RUN_CTRL, 16'h0001);
      repeat (5) begin
         wdog_service = 1'b1;
         cyc(1);
         wdog_service = 1'b0;
         cyc(20);
      end
      `CHK(drive_enable, 1'b1)
      cyc(60);
      `CHK(drive_enable, 1'b0)
      host.rd(`OFS_FAULT_OUTPUT_PIN, d); `CHK(d[12], 1'b1)
      host.rd(`OFS_RUN_CTRL, d); `CHK(d[0], 1'b0)
      // Clear stops a running drive
      clr();
      host.wr(`OFS_RUN_CTRL, 16'h0005);
      cyc(3);
      `CHK(brake_out, 1'b1)
      `CHK(drive_enable, 1'b1)
      host.set_clear(1'b0);
      cyc(4);
      `CHK(drive_enable, 1'b0)
      host.set_clear(1'b1);
      cyc(4);
      // Pin fed by memory error and memory flags only
      host.wr(`OFS_FAULT_OUTPUT_PIN, 16'h0010);
      cyc(3);
      `CHK(fault_output_pin, 1'b1)
      memory_error_event = 1'b1;
      cyc(5);
      `CHK(fault_output_pin, 1'b0)
      host.rd(`OFS_FAULT_OUTPUT_PIN, d); `CHK(d[13], 1'b1)
      memory_error_event = 1'b0;
      host.wr(`OFS_FAULT_OUTPUT_PIN, 16'h0000);
      // Save, refused second save, count
      host.wr(`OFS_NV_SAVE, 16'h0200);
      for (n = 0; n < 4 && nv_save_trigger !== 1'b1; n++) cyc(1);
      `CHK(nv_save_trigger, 1'b1)
      host.wr(`OFS_NV_SAVE, 16'h0200);
      nv_done = 1'b1;
      cyc(1);
      nv_done = 1'b0;
      cyc(2);
      host.rd(`OFS_NV_SAVE, d); `CHK(d, 16'h0001)
      host.rd(`OFS_FAULT_OUTPUT_PIN, d); `CHK(d[10], 1'b1)
      // Save ended by its time limit
      host.wr(`OFS_NV_SAVE, 16'h0200);
      cyc(410);
      host.rd(`OFS_NV_SAVE, d); `CHK(d, 16'h0002)
      // Configuration selects and low power
      host.wr(`OFS_CFG18, 16'h0376);
      host.wr(`OFS_CFG19, 16'h01b2);
      analog_speed_low = 1'b1;
      cyc(30);
      `CHK(pulse_rate_select, 1'b1)
      `CHK(speed_from_serial, 1'b0)
      `CHK(low_power, 1'b1)
      end_sim();
   end
endmodule // motor_drive_control_fault_output_pin_regs_test

`default_nettype wire
